/* verilog/ofl_pkg.sv */
// Purpose: Shared constants for the output fault live status bank
// Assumes: 8-bit registers on an 8-bit register access port
// Notes: Threshold codes are 8 bits scaled by 16 against a 12-bit monitor result
package ofl_pkg;

  // Register offsets
  localparam logic [7:0] OFL_OFF_CH1_LATCH = 8'h38;
  localparam logic [7:0] OFL_OFF_CH2_LATCH = 8'h39;
  localparam logic [7:0] OFL_OFF_HS_LATCH = 8'h3A;
  localparam logic [7:0] OFL_OFF_MV_LATCH = 8'h3B;
  localparam logic [7:0] OFL_OFF_CH1_LIVE = 8'h40;
  localparam logic [7:0] OFL_OFF_CH2_LIVE = 8'h41;
  localparam logic [7:0] OFL_OFF_HS_LIVE = 8'h42;
  localparam logic [7:0] OFL_OFF_MV_LIVE = 8'h43;
  localparam logic [7:0] OFL_OFF_HIGH_THR = 8'h4E;
  localparam logic [7:0] OFL_OFF_LOW_THR = 8'h4F;

  // Reset values
  localparam logic [7:0] OFL_RST_STATUS = 8'h00;
  localparam logic [7:0] OFL_RST_HIGH_THR = 8'hBA;
  localparam logic [7:0] OFL_RST_LOW_THR = 8'h4B;

  // Field positions, output channel registers
  localparam int OFL_SHORT_POS_BIT = 7;
  localparam int OFL_SHORT_NEG_BIT = 6;
  localparam int OFL_VG_POS_BIT = 5;
  localparam int OFL_VG_NEG_BIT = 4;
  localparam int OFL_REG_SHORT_BIT = 0;
  // Field positions, event registers
  localparam int OFL_HS_INSERT_BIT = 3;
  localparam int OFL_HS_REMOVE_BIT = 2;
  localparam int OFL_HS_BUTTON_BIT = 1;
  localparam int OFL_MON_UP_BIT = 7;
  localparam int OFL_MON_LOW_BIT = 6;
  localparam int OFL_VOICE_UP_BIT = 5;
  localparam int OFL_VOICE_DOWN_BIT = 4;

  // Implemented-bit masks; everything else reads zero
  localparam logic [7:0] OFL_MASK_CH1 = 8'hF0;
  localparam logic [7:0] OFL_MASK_CH2 = 8'hF1;
  localparam logic [7:0] OFL_MASK_HS = 8'h0E;
  localparam logic [7:0] OFL_MASK_MV = 8'hF0;

  // Monitor scaling
  localparam int OFL_MON_WIDTH = 12;
  localparam logic [11:0] OFL_MON_FULL_SCALE = 12'hFFF;
  localparam int OFL_THR_SHIFT = 4;

  // Threshold code to 12-bit monitor level: N*16 on a 4095 full scale
  function automatic logic [11:0] ofl_thr_level(input logic [7:0] thr);
    ofl_thr_level = {thr, 4'h0};
  endfunction : ofl_thr_level

endpackage : ofl_pkg

/* verilog/ofl_thr_cmp.sv */
// Purpose: Upper and lower threshold fault flags for the analog monitor
// Assumes: Monitor result and valid come from logic on clk_i
// Notes: Equality holds the current flag state, giving one code of hysteresis
`timescale 1ns/10ps
module ofl_thr_cmp (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Monitor conversion
  input wire logic mon_valid_i,
  input wire logic [11:0] mon_result_i,
  // Thresholds
  input wire logic [7:0] high_thr_i,
  input wire logic [7:0] low_thr_i,
  // Fault flags
  output logic up_flt_o,
  output logic low_flt_o
);
  import ofl_pkg::*;

  typedef struct packed {
    logic up;
    logic low;
  } ofl_cmp_state_t;

  ofl_cmp_state_t st;
  ofl_cmp_state_t next_st;
  logic [11:0] hi_lvl;
  logic [11:0] lo_lvl;

  assign hi_lvl = ofl_thr_level(high_thr_i);
  assign lo_lvl = ofl_thr_level(low_thr_i);

  always_comb begin
    next_st = st;
    if (mon_valid_i) begin
      if (mon_result_i > hi_lvl) begin
        next_st.up = 1'b1;
      end else if (mon_result_i < hi_lvl) begin
        next_st.up = 1'b0;
      end
      if (mon_result_i < lo_lvl) begin
        next_st.low = 1'b1;
      end else if (mon_result_i > lo_lvl) begin
        next_st.low = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign up_flt_o = st.up;
  assign low_flt_o = st.low;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_upper_fault_set: assert property (mon_valid_i && mon_result_i > {high_thr_i, 4'h0} |=> up_flt_o)
    else $error("upper fault not set above threshold");
  a_upper_fault_clr: assert property (mon_valid_i && mon_result_i < {high_thr_i, 4'h0} |=> !up_flt_o)
    else $error("upper fault not cleared below threshold");
  a_lower_fault_set: assert property (mon_valid_i && mon_result_i < {low_thr_i, 4'h0} |=> low_flt_o)
    else $error("lower fault not set below threshold");
  a_flags_hold_idle: assert property (!mon_valid_i |=> $stable(up_flt_o) && $stable(low_flt_o))
    else $error("fault flag moved without a conversion");

endmodule : ofl_thr_cmp

/* verilog/ofl_status_bank.sv */
// Purpose: Live and latched output fault and event status bank with monitor thresholds
// Assumes: Fault and event inputs are asynchronous levels; register port is on clk_i
// Notes: Read data appear one cycle after the read strobe
`timescale 1ns/10ps
module ofl_status_bank (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register access port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Output channel fault detectors
  input wire logic first_positive_output_short_i,
  input wire logic first_negative_output_short_i,
  input wire logic first_positive_driver_vg_i,
  input wire logic first_negative_driver_vg_i,
  input wire logic second_positive_output_short_i,
  input wire logic second_negative_output_short_i,
  input wire logic second_positive_driver_vg_i,
  input wire logic second_negative_driver_vg_i,
  input wire logic analog_regulator_short_i,
  // Headset and voice activity detectors
  input wire logic headset_insert_i,
  input wire logic headset_remove_i,
  input wire logic headset_button_i,
  input wire logic voice_activity_up_i,
  input wire logic voice_activity_down_i,
  // General analog monitor conversion
  input wire logic mon_valid_i,
  input wire logic [ofl_pkg::OFL_MON_WIDTH-1:0] mon_result_i,
  // Threshold outputs for the monitor path
  output logic [7:0] monitor_upper_limit_o,
  output logic [7:0] monitor_lower_limit_o
);
  import ofl_pkg::*;

  typedef struct packed {
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [7:0] high_thr;
    logic [7:0] low_thr;
    logic [7:0] lt_ch1;
    logic [7:0] lt_ch2;
    logic [7:0] lt_hs;
    logic [7:0] lt_mv;
    logic [7:0] rdata;
    logic rvalid;
  } ofl_bank_state_t;

  ofl_bank_state_t st;
  ofl_bank_state_t next_st;

  logic [31:0] raw;
  logic [7:0] first_channel_fault_bits;
  logic [7:0] second_channel_fault_bits;
  logic [7:0] headset_event_bits;
  logic [7:0] monitor_voice_event_bits;
  logic up_flt;
  logic low_flt;

  // Pin levels packed into register layout before the two-flop synchroniser
  always_comb begin
    raw = '0;
    raw[24 + OFL_SHORT_POS_BIT] = first_positive_output_short_i;
    raw[24 + OFL_SHORT_NEG_BIT] = first_negative_output_short_i;
    raw[24 + OFL_VG_POS_BIT] = first_positive_driver_vg_i;
    raw[24 + OFL_VG_NEG_BIT] = first_negative_driver_vg_i;
    raw[16 + OFL_SHORT_POS_BIT] = second_positive_output_short_i;
    raw[16 + OFL_SHORT_NEG_BIT] = second_negative_output_short_i;
    raw[16 + OFL_VG_POS_BIT] = second_positive_driver_vg_i;
    raw[16 + OFL_VG_NEG_BIT] = second_negative_driver_vg_i;
    raw[16 + OFL_REG_SHORT_BIT] = analog_regulator_short_i;
    raw[8 + OFL_HS_INSERT_BIT] = headset_insert_i;
    raw[8 + OFL_HS_REMOVE_BIT] = headset_remove_i;
    raw[8 + OFL_HS_BUTTON_BIT] = headset_button_i;
    raw[OFL_VOICE_UP_BIT] = voice_activity_up_i;
    raw[OFL_VOICE_DOWN_BIT] = voice_activity_down_i;
  end

  ofl_thr_cmp u_thr_cmp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mon_valid_i(mon_valid_i),
    .mon_result_i(mon_result_i),
    .high_thr_i(st.high_thr),
    .low_thr_i(st.low_thr),
    .up_flt_o(up_flt),
    .low_flt_o(low_flt)
  );

  // Masks keep reserved bits at zero however the sync vector is laid out
  assign first_channel_fault_bits = st.sync2[31:24] & OFL_MASK_CH1;
  assign second_channel_fault_bits = st.sync2[23:16] & OFL_MASK_CH2;
  assign headset_event_bits = st.sync2[15:8] & OFL_MASK_HS;
  always_comb begin
    monitor_voice_event_bits = st.sync2[7:0] & OFL_MASK_MV;
    monitor_voice_event_bits[OFL_MON_UP_BIT] = up_flt;
    monitor_voice_event_bits[OFL_MON_LOW_BIT] = low_flt;
  end

  always_comb begin
    next_st = st;
    next_st.sync1 = raw;
    next_st.sync2 = st.sync1;
    next_st.rvalid = reg_rd_i;
    // Latched copies accumulate live bits; a read clears, but a live bit in the
    // same cycle sets again so no event slips through the clear
    next_st.lt_ch1 = st.lt_ch1 | first_channel_fault_bits;
    next_st.lt_ch2 = st.lt_ch2 | second_channel_fault_bits;
    next_st.lt_hs = st.lt_hs | headset_event_bits;
    next_st.lt_mv = st.lt_mv | monitor_voice_event_bits;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFL_OFF_CH1_LIVE: next_st.rdata = first_channel_fault_bits;
        OFL_OFF_CH2_LIVE: next_st.rdata = second_channel_fault_bits;
        OFL_OFF_HS_LIVE: next_st.rdata = headset_event_bits;
        OFL_OFF_MV_LIVE: next_st.rdata = monitor_voice_event_bits;
        OFL_OFF_HIGH_THR: next_st.rdata = st.high_thr;
        OFL_OFF_LOW_THR: next_st.rdata = st.low_thr;
        OFL_OFF_CH1_LATCH: begin
          next_st.rdata = st.lt_ch1;
          next_st.lt_ch1 = first_channel_fault_bits;
        end
        OFL_OFF_CH2_LATCH: begin
          next_st.rdata = st.lt_ch2;
          next_st.lt_ch2 = second_channel_fault_bits;
        end
        OFL_OFF_HS_LATCH: begin
          next_st.rdata = st.lt_hs;
          next_st.lt_hs = headset_event_bits;
        end
        OFL_OFF_MV_LATCH: begin
          next_st.rdata = st.lt_mv;
          next_st.lt_mv = monitor_voice_event_bits;
        end
        default: next_st.rdata = 8'h00;
      endcase
    end
    // Only the two thresholds take writes; status registers ignore them
    if (reg_wr_i && reg_addr_i == OFL_OFF_HIGH_THR) begin
      next_st.high_thr = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == OFL_OFF_LOW_THR) begin
      next_st.low_thr = reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.high_thr <= OFL_RST_HIGH_THR;
      st.low_thr <= OFL_RST_LOW_THR;
      st.rdata <= OFL_RST_STATUS;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o = st.rdata;
  assign reg_rvalid_o = st.rvalid;
  assign monitor_upper_limit_o = st.high_thr;
  assign monitor_lower_limit_o = st.low_thr;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rd(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence

  sequence s_pin_steady(logic p);
    $stable(p) [*3];
  endsequence

  a_ch1_short_live: assert property (s_pin_steady(first_positive_output_short_i) ##0 s_rd(OFL_OFF_CH1_LIVE)
    |=> reg_rvalid_o && reg_rdata_o[7] == $past(first_positive_output_short_i) && reg_rdata_o[3:0] == 4'h0)
    else $error("channel one short bit wrong");
  a_ch1_vg_live: assert property (s_pin_steady(first_negative_driver_vg_i) ##0 s_rd(OFL_OFF_CH1_LIVE)
    |=> reg_rdata_o[4] == $past(first_negative_driver_vg_i))
    else $error("channel one virtual ground bit wrong");
  a_ch2_reg_short: assert property (s_pin_steady(analog_regulator_short_i) ##0 s_rd(OFL_OFF_CH2_LIVE)
    |=> reg_rdata_o[0] == $past(analog_regulator_short_i) && reg_rdata_o[3:1] == 3'h0)
    else $error("regulator short bit wrong");
  a_ch2_short_live: assert property (s_pin_steady(second_negative_output_short_i) ##0 s_rd(OFL_OFF_CH2_LIVE)
    |=> reg_rdata_o[6] == $past(second_negative_output_short_i))
    else $error("channel two short bit wrong");
  a_headset_live: assert property (s_pin_steady(headset_remove_i) ##0 s_rd(OFL_OFF_HS_LIVE)
    |=> reg_rdata_o[2] == $past(headset_remove_i) && (reg_rdata_o & ~OFL_MASK_HS) == 8'h00)
    else $error("headset event bits wrong");
  a_monitor_live: assert property (s_rd(OFL_OFF_MV_LIVE)
    |=> reg_rdata_o[7] == $past(up_flt) && reg_rdata_o[6] == $past(low_flt) && reg_rdata_o[3:0] == 4'h0)
    else $error("monitor event bits wrong");
  a_vad_live: assert property (s_pin_steady(voice_activity_up_i) ##0 s_rd(OFL_OFF_MV_LIVE)
    |=> reg_rdata_o[5] == $past(voice_activity_up_i))
    else $error("voice activity bit wrong");
  a_high_thr_write: assert property (reg_wr_i && reg_addr_i == OFL_OFF_HIGH_THR ##1 !reg_wr_i ##1 s_rd(OFL_OFF_HIGH_THR)
    |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("upper threshold readback wrong");
  a_latch_hold: assert property (!(reg_rd_i && reg_addr_i == OFL_OFF_HS_LATCH) |=> (st.lt_hs & $past(st.lt_hs)) == $past(st.lt_hs))
    else $error("latched headset bit lost without its read");
  a_latch_clear: assert property (s_rd(OFL_OFF_HS_LATCH) |=> st.lt_hs == $past(headset_event_bits))
    else $error("latched headset register not cleared by read");

endmodule : ofl_status_bank

/* tb/ofl_host_model.sv */
// Purpose: Host controller model that reads and writes the status bank registers
// Assumes: Same-clock strobe port; read data arrive exactly one cycle after the strobe
// Notes: Address and write data show the inverse of the last value when idle
`timescale 1ns/10ps
module ofl_host_model (
  // Clock
  input wire logic clk_i,
  // Register port, host side
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = v;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~v;
  endtask : wr

  // The answer stands one cycle only, so it is taken at the next falling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    ok = (reg_rvalid_i === 1'b1);
    d = reg_rdata_i;
  endtask : rd
endmodule : ofl_host_model

/* tb/testbench.sv */
// Purpose: Self-checking bench for the output fault live status bank
// Assumes: Pins change on the falling edge and settle through a two-flop synchroniser
// Notes: Random pin patterns come from a 16-bit shift register seeded with 25
`timescale 1ns/10ps
module testbench;
  import ofl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, mon_up, mon_low, d, thr;
  logic reg_wr, reg_rd, reg_rvalid, ok;
  logic mon_valid = 1'b0;
  logic [11:0] mon_result = 12'h000;
  logic [13:0] p = 14'h0000;
  logic [15:0] seed = 16'h0019;
  int err_count = 0;
  int cmp_count = 0;

  always #10 clk_i = ~clk_i;

  ofl_host_model host (.clk_i(clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata),
    .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid));

  ofl_status_bank DUT (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
    .first_positive_output_short_i(p[0]), .first_negative_output_short_i(p[1]),
    .first_positive_driver_vg_i(p[2]), .first_negative_driver_vg_i(p[3]),
    .second_positive_output_short_i(p[4]), .second_negative_output_short_i(p[5]),
    .second_positive_driver_vg_i(p[6]), .second_negative_driver_vg_i(p[7]),
    .analog_regulator_short_i(p[8]), .headset_insert_i(p[9]), .headset_remove_i(p[10]),
    .headset_button_i(p[11]), .voice_activity_up_i(p[12]), .voice_activity_down_i(p[13]),
    .mon_valid_i(mon_valid), .mon_result_i(mon_result),
    .monitor_upper_limit_o(mon_up), .monitor_lower_limit_o(mon_low));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic logic [7:0] exp_ch1(input logic [13:0] v);
    return {v[0], v[1], v[2], v[3], 4'h0};
  endfunction : exp_ch1

  function automatic logic [7:0] exp_ch2(input logic [13:0] v);
    return {v[4], v[5], v[6], v[7], 3'h0, v[8]};
  endfunction : exp_ch2

  function automatic logic [7:0] exp_hs(input logic [13:0] v);
    return {4'h0, v[9], v[10], v[11], 1'b0};
  endfunction : exp_hs

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // A missing read answer is a hang in disguise, so the run stops there
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, d, ok);
    if (!ok) begin
      err_count++;
      $display("[FAIL] %0t no read answer at %h", $time, a);
      complete_run();
    end
    check(d, exp);
  endtask : rd_chk

  task automatic mon(input logic [11:0] r);
    @(negedge clk_i);
    mon_result = r;
    mon_valid = 1'b1;
    @(negedge clk_i);
    mon_valid = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask : mon

  initial begin
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    rd_chk(OFL_OFF_CH1_LIVE, 8'h00);
    rd_chk(OFL_OFF_CH2_LIVE, 8'h00);
    rd_chk(OFL_OFF_HS_LIVE, 8'h00);
    rd_chk(OFL_OFF_MV_LIVE, 8'h00);
    rd_chk(OFL_OFF_HIGH_THR, 8'hBA);
    rd_chk(OFL_OFF_LOW_THR, 8'h4B);
    check(mon_up, 8'hBA);
    $display("Reset values done");
    for (int i = 0; i < 14; i++) begin
      seed = lfsr_next(seed);
      @(negedge clk_i);
      p = (i == 13) ? 14'h3FFF : seed[13:0];
      repeat (3) @(negedge clk_i);
      rd_chk(OFL_OFF_CH1_LIVE, exp_ch1(p));
      rd_chk(OFL_OFF_CH2_LIVE, exp_ch2(p));
      rd_chk(OFL_OFF_HS_LIVE, exp_hs(p));
      rd_chk(OFL_OFF_MV_LIVE, {2'h0, p[12], p[13], 4'h0});
    end
    host.wr(OFL_OFF_CH1_LIVE, 8'h0F);
    host.wr(OFL_OFF_HS_LIVE, 8'hFF);
    rd_chk(OFL_OFF_CH1_LIVE, 8'hF0);
    rd_chk(OFL_OFF_CH1_LIVE, 8'hF0);
    rd_chk(OFL_OFF_HS_LIVE, 8'h0E);
    rd_chk(8'h7F, 8'h00);
    rd_chk(OFL_OFF_CH1_LATCH, 8'hF0);
    rd_chk(OFL_OFF_CH2_LATCH, 8'hF1);
    rd_chk(OFL_OFF_HS_LATCH, 8'h0E);
    rd_chk(OFL_OFF_MV_LATCH, 8'h30);
    $display("Live status done");
    @(negedge clk_i);
    p = 14'h0000;
    seed = lfsr_next(seed);
    thr = {1'b1, seed[6:0]};
    host.wr(OFL_OFF_LOW_THR, 8'h01);
    host.wr(OFL_OFF_HIGH_THR, thr);
    check(mon_up, thr);
    check(mon_low, 8'h01);
    rd_chk(OFL_OFF_HIGH_THR, thr);
    mon({thr, 4'h0} + 12'h001);
    rd_chk(OFL_OFF_MV_LIVE, 8'h80);
    mon({thr, 4'h0});
    rd_chk(OFL_OFF_MV_LIVE, 8'h80);
    mon({thr, 4'h0} - 12'h001);
    rd_chk(OFL_OFF_MV_LIVE, 8'h00);
    mon(12'h000);
    rd_chk(OFL_OFF_MV_LIVE, 8'h40);
    $display("Monitor thresholds done");
    host.rd(OFL_OFF_HS_LATCH, d, ok);
    @(negedge clk_i);
    p[9] = 1'b1;
    repeat (4) @(negedge clk_i);
    p[9] = 1'b0;
    repeat (4) @(negedge clk_i);
    rd_chk(OFL_OFF_HS_LATCH, 8'h08);
    rd_chk(OFL_OFF_HS_LATCH, 8'h00);
    rd_chk(OFL_OFF_HS_LIVE, 8'h00);
    $display("Latched events done");
    complete_run();
  end
endmodule : testbench
